// ---- design/fbep_defs.svh ----
// constants for the flash erase and protection controller
`ifndef FBEP_DEFS_SVH
`define FBEP_DEFS_SVH

// array geometry in bytes and 32-bit words
`define FBEP_ARRAY_BYTES   262144
`define FBEP_DATA_W        32
`define FBEP_WORDS         65536
`define FBEP_WADDR_W       16

// erase unit of 1 KB, 256 words, selected by word address bits [15:8]
`define FBEP_UNIT_BYTES    1024
`define FBEP_UNIT_WORDS    256
`define FBEP_UNIT_LSB      8
`define FBEP_UNIT_W        8
`define FBEP_UNIT_LAST     8'hff

// protection granule of 2 KB, two erase units, word address bits [15:9]
`define FBEP_GRAN_BYTES    2048
`define FBEP_GRAN_LSB      9
`define FBEP_GRAN_W        7
`define FBEP_GRAN_NUM      128

// an erased word reads as all ones
`define FBEP_ERASED_WORD   32'hffffffff
`define FBEP_ZERO_WORD     32'h00000000

`endif

// ---- design/fbep_pkg.sv ----
// types for the flash erase and protection controller
`include "fbep_defs.svh"

package fbep_pkg;

  typedef logic [`FBEP_WADDR_W-1:0] fbep_waddr_t;
  typedef logic [`FBEP_DATA_W-1:0]  fbep_word_t;
  typedef logic [`FBEP_UNIT_W-1:0]  fbep_unit_t;
  typedef logic [`FBEP_GRAN_W-1:0]  fbep_gran_t;

  // who issues a read
  typedef enum logic [1:0] {
    FBEP_SRC_IFETCH,
    FBEP_SRC_DATA,
    FBEP_SRC_DEBUG
  } fbep_src_t;

  // modifying commands
  typedef enum logic {
    FBEP_CMD_PROGRAM,
    FBEP_CMD_ERASE
  } fbep_cmd_t;

  typedef enum logic {
    FBEP_ST_IDLE,
    FBEP_ST_ERASE
  } fbep_wstate_t;

  typedef struct packed {
    fbep_wstate_t st;
    fbep_unit_t   unit;
    fbep_unit_t   cnt;
    logic         rd_valid;
    logic         rd_fault;
    logic         wr_done;
    logic         wr_fault;
  } fbep_ctrl_st_t;

endpackage

// ---- design/fbep_array.sv ----
// flash storage array: one registered read port, one write port
`timescale 1ns/10ps
`include "fbep_defs.svh"

module fbep_array
  import fbep_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  // read port
  input  wire logic              i_rd_en,
  input  wire fbep_pkg::fbep_waddr_t i_rd_addr,
  output fbep_pkg::fbep_word_t   o_rd_data,
  // write port
  input  wire logic              i_wr_en,
  input  wire logic              i_wr_erase,
  input  wire fbep_pkg::fbep_waddr_t i_wr_addr,
  input  wire fbep_pkg::fbep_word_t  i_wr_data
);

  // contents are not reset: the array models non-volatile storage
  fbep_word_t mem [0:`FBEP_WORDS-1];
  fbep_word_t rd_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_wr_en)
    begin
      if (i_wr_erase)
        mem[i_wr_addr] <= `FBEP_ERASED_WORD;
      else
        mem[i_wr_addr] <= mem[i_wr_addr] & i_wr_data; // programming only clears bits
    end
  end

  // a disabled read loads zero so no stale contents leak after a refusal
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rd_q <= `FBEP_ZERO_WORD;
    else if (i_rd_en)
      rd_q <= mem[i_rd_addr];
    else
      rd_q <= `FBEP_ZERO_WORD;
  end

  assign o_rd_data = rd_q;

endmodule

// ---- design/fbep_ctrl.sv ----
// flash controller: erase units, protection granules and access checks
//
// Overview of operation
// - array holds 256 KB behind this controller
// - 1 KB units erase alone, others untouched
// - erased unit reads back as all ones
// - protection held per 2 KB unit pair
// - read-only granule refuses erase and program
// - execute-only granule refuses erase and program
// - execute-only granule serves instruction fetch only
// - permitted read completes in one clock
`timescale 1ns/10ps
`include "fbep_defs.svh"

module fbep_ctrl
  import fbep_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_b,
  // protection attributes, one bit per 2 KB granule
  input  wire logic [`FBEP_GRAN_NUM-1:0] i_prot_ro,
  input  wire logic [`FBEP_GRAN_NUM-1:0] i_prot_xo,
  // read requests
  input  wire logic                  i_rd_req,
  input  wire fbep_pkg::fbep_src_t   i_rd_src,
  input  wire fbep_pkg::fbep_waddr_t i_rd_addr,
  output logic                       o_rd_valid,
  output fbep_pkg::fbep_word_t       o_rd_data,
  output logic                       o_rd_fault,
  // program and erase requests
  input  wire logic                  i_wr_req,
  input  wire fbep_pkg::fbep_cmd_t   i_wr_cmd,
  input  wire fbep_pkg::fbep_waddr_t i_wr_addr,
  input  wire fbep_pkg::fbep_word_t  i_wr_data,
  output logic                       o_wr_ready,
  output logic                       o_wr_done,
  output logic                       o_wr_fault
);

  import fbep_pkg::*;

  fbep_ctrl_st_t s_q;
  fbep_ctrl_st_t s_d;

  // array write controls, built alongside the next state
  logic       arr_wr_en;
  logic       arr_wr_erase;
  fbep_waddr_t arr_wr_addr;
  fbep_word_t arr_wr_data;
  logic       arr_rd_en;

  logic       rd_ok;
  logic       wr_ok;

  // granule index of a word address
  function automatic fbep_gran_t gran_of(input fbep_waddr_t a);
    gran_of = a[`FBEP_WADDR_W-1:`FBEP_GRAN_LSB];
  endfunction

  // erase unit index of a word address
  function automatic fbep_unit_t unit_of(input fbep_waddr_t a);
    unit_of = a[`FBEP_WADDR_W-1:`FBEP_UNIT_LSB];
  endfunction

  // a granule may be modified only with neither attribute set
  function automatic logic may_modify(input fbep_gran_t g,
                                      input logic [`FBEP_GRAN_NUM-1:0] ro,
                                      input logic [`FBEP_GRAN_NUM-1:0] xo);
    may_modify = !ro[g] && !xo[g];
  endfunction

  // read permission; code 3 is no legal source, so it is refused like a debugger
  function automatic logic may_read(input fbep_gran_t g,
                                    input fbep_src_t  src,
                                    input logic [`FBEP_GRAN_NUM-1:0] xo);
    logic fetch;
    fetch = 1'b0;
    unique case (src)
      FBEP_SRC_IFETCH:
        fetch = 1'b1;
      FBEP_SRC_DATA,
      FBEP_SRC_DEBUG:
        fetch = 1'b0;
      default:
        fetch = 1'b0;
    endcase
    may_read = !xo[g] || fetch;
  endfunction

  // word address of one step of the erase walk
  function automatic fbep_waddr_t unit_word(input fbep_unit_t u,
                                            input fbep_unit_t step);
    unit_word = {u, step};
  endfunction

  // true on the last word of an erase unit
  function automatic logic unit_last(input fbep_unit_t step);
    unit_last = (step == `FBEP_UNIT_LAST);
  endfunction

  always_comb
  begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    s_d.rd_fault = 1'b0;
    s_d.wr_done  = 1'b0;
    s_d.wr_fault = 1'b0;
    arr_wr_en    = 1'b0;
    arr_wr_erase = 1'b0;
    arr_wr_addr  = i_wr_addr;
    arr_wr_data  = i_wr_data;

    // reads run beside any erase; the array has separate ports
    rd_ok     = may_read(gran_of(i_rd_addr), i_rd_src, i_prot_xo);
    arr_rd_en = i_rd_req && rd_ok;
    if (i_rd_req)
    begin
      s_d.rd_valid = 1'b1;
      s_d.rd_fault = !rd_ok;
    end

    // attributes count only at the take; a running erase is not aborted
    wr_ok = may_modify(gran_of(i_wr_addr), i_prot_ro, i_prot_xo);

    unique case (s_q.st)
      FBEP_ST_IDLE:
      begin
        if (i_wr_req)
        begin
          if (!wr_ok)
          begin
            s_d.wr_fault = 1'b1;
            s_d.wr_done  = 1'b1;
          end
          else if (i_wr_cmd == FBEP_CMD_PROGRAM)
          begin
            // programming can only clear bits; only an erase brings ones back
            arr_wr_en   = 1'b1;
            s_d.wr_done = 1'b1;
          end
          else
          begin
            // erase walks the unit one word per clock
            s_d.st   = FBEP_ST_ERASE;
            s_d.unit = unit_of(i_wr_addr);
            s_d.cnt  = '0;
          end
        end
      end
      FBEP_ST_ERASE:
      begin
        arr_wr_en    = 1'b1;
        arr_wr_erase = 1'b1;
        arr_wr_addr  = unit_word(s_q.unit, s_q.cnt);
        arr_wr_data  = `FBEP_ERASED_WORD;
        s_d.cnt      = s_q.cnt + 1'b1;
        // reads during the walk see a partly erased unit
        if (unit_last(s_q.cnt))
        begin
          s_d.st      = FBEP_ST_IDLE;
          s_d.cnt     = '0;
          s_d.wr_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s_q.st       <= FBEP_ST_IDLE;
      s_q.unit     <= '0;
      s_q.cnt      <= '0;
      s_q.rd_valid <= 1'b0;
      s_q.rd_fault <= 1'b0;
      s_q.wr_done  <= 1'b0;
      s_q.wr_fault <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // 256 KB of storage, 65536 words
  fbep_array fbep_array_inst (
    .i_clk_sys  (i_clk_sys),
    .i_rst_b    (i_rst_b),
    .i_rd_en    (arr_rd_en),
    .i_rd_addr  (i_rd_addr),
    .o_rd_data  (o_rd_data),
    .i_wr_en    (arr_wr_en),
    .i_wr_erase (arr_wr_erase),
    .i_wr_addr  (arr_wr_addr),
    .i_wr_data  (arr_wr_data)
  );

  // a new command is taken only while no erase is walking
  assign o_wr_ready = (s_q.st == FBEP_ST_IDLE);
  assign o_rd_valid = s_q.rd_valid;
  assign o_rd_fault = s_q.rd_fault;
  assign o_wr_done  = s_q.wr_done;
  assign o_wr_fault = s_q.wr_fault;

endmodule

// ---- verification/fbep_ctrl_chk.sv ----
// port assertions for the flash protection controller
`timescale 1ns/10ps
`include "fbep_defs.svh"
module fbep_chk
  import fbep_pkg::*;
(
  input wire logic                       i_clk_sys,
  input wire logic                       i_rst_b,
  input wire logic [`FBEP_GRAN_NUM-1:0] i_prot_ro,
  input wire logic [`FBEP_GRAN_NUM-1:0] i_prot_xo,
  input wire logic                       i_rd_req,
  input wire fbep_pkg::fbep_src_t        i_rd_src,
  input wire fbep_pkg::fbep_waddr_t      i_rd_addr,
  input wire logic                       o_rd_valid,
  input wire fbep_pkg::fbep_word_t       o_rd_data,
  input wire logic                       o_rd_fault,
  input wire logic                       i_wr_req,
  input wire fbep_pkg::fbep_cmd_t        i_wr_cmd,
  input wire fbep_pkg::fbep_waddr_t      i_wr_addr,
  input wire fbep_pkg::fbep_word_t       i_wr_data,
  input wire logic                       o_wr_ready,
  input wire logic                       o_wr_done,
  input wire logic                       o_wr_fault
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic rd_xo;
  logic take;
  logic prot;
  logic erase_go;
  assign rd_xo = i_prot_xo[i_rd_addr[15:9]] && i_rd_src != FBEP_SRC_IFETCH;
  assign take = i_wr_req && o_wr_ready;
  assign prot = i_prot_ro[i_wr_addr[15:9]] || i_prot_xo[i_wr_addr[15:9]];
  assign erase_go = take && !prot && i_wr_cmd == FBEP_CMD_ERASE;
  read_answer_a: assert property (i_rd_req |=> o_rd_valid)
    else $error("read not answered next cycle");
  read_idle_a: assert property (!i_rd_req
    |=> !o_rd_valid && !o_rd_fault && o_rd_data == 0)
    else $error("read output without request");
  xo_deny_a: assert property (i_rd_req && rd_xo |=> o_rd_fault && o_rd_data == 0)
    else $error("guarded read not refused");
  xo_fetch_a: assert property (i_rd_req && !rd_xo |=> !o_rd_fault)
    else $error("permitted read refused");
  prot_refuse_a: assert property (take && prot
    |=> o_wr_done && o_wr_fault && o_wr_ready)
    else $error("protected command not refused");
  prog_done_a: assert property (take && !prot && i_wr_cmd == FBEP_CMD_PROGRAM
    |=> o_wr_done && !o_wr_fault)
    else $error("program not completed");
  erase_busy_a: assert property (erase_go |=> !o_wr_ready [*8])
    else $error("erase not busy");
  erase_done_a: assert property (erase_go |-> ##257 (o_wr_done && !o_wr_fault))
    else $error("erase length wrong");
  done_pair_a: assert property (o_wr_fault |-> o_wr_done)
    else $error("fault without done");
  cover property (erase_go);
  cover property (i_rd_req && rd_xo);
  cover property (take && prot);
endmodule

bind fbep_ctrl fbep_chk fbep_chk_inst (.i_clk_sys, .i_rst_b, .i_prot_ro, .i_prot_xo, .i_rd_req,
  .i_rd_src, .i_rd_addr, .o_rd_valid, .o_rd_data, .o_rd_fault, .i_wr_req, .i_wr_cmd,
  .i_wr_addr, .i_wr_data, .o_wr_ready, .o_wr_done, .o_wr_fault);

// ---- verification/fbep_req_model.sv ----
// read requester model: fetch, data path and debugger
`timescale 1ns/10ps
module fbep_req_model
  import fbep_pkg::*;
(
  input  wire logic          i_clk_sys,
  output logic               o_rd_req,
  output fbep_pkg::fbep_src_t   o_rd_src,
  output fbep_pkg::fbep_waddr_t o_rd_addr
);
  initial
  begin
    o_rd_req = 1'b0;
    o_rd_src = FBEP_SRC_IFETCH;
    o_rd_addr = 16'h0000;
  end
  // address flips after the request so a stale value cannot pass
  task automatic issue(input fbep_src_t s, input fbep_waddr_t a);
    @(posedge i_clk_sys) #1;
    o_rd_req = 1'b1;
    o_rd_src = s;
    o_rd_addr = a;
    @(posedge i_clk_sys) #1;
    o_rd_req = 1'b0;
    o_rd_addr = ~a;
  endtask
endmodule

// ---- verification/tb_flash_block_erase_protect.sv ----
// self-checking bench for the flash protection controller
`timescale 1ns/10ps
`include "fbep_defs.svh"
module tb_flash_block_erase_protect;
  import fbep_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [`FBEP_GRAN_NUM-1:0] i_prot_ro = '0;
  logic [`FBEP_GRAN_NUM-1:0] i_prot_xo = '0;
  logic i_rd_req, o_rd_valid, o_rd_fault, o_wr_ready, o_wr_done, o_wr_fault;
  logic i_wr_req = 1'b0;
  fbep_src_t i_rd_src;
  fbep_cmd_t i_wr_cmd = FBEP_CMD_PROGRAM;
  fbep_waddr_t i_rd_addr;
  fbep_waddr_t i_wr_addr = 16'h0000;
  fbep_word_t i_wr_data = 32'h0;
  fbep_word_t o_rd_data;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  fbep_ctrl fbep_ctrl_inst (.i_clk_sys, .i_rst_b, .i_prot_ro, .i_prot_xo, .i_rd_req, .i_rd_src,
    .i_rd_addr, .o_rd_valid, .o_rd_data, .o_rd_fault, .i_wr_req, .i_wr_cmd, .i_wr_addr,
    .i_wr_data, .o_wr_ready, .o_wr_done, .o_wr_fault);
  fbep_req_model fbep_req_model_inst (.i_clk_sys, .o_rd_req(i_rd_req), .o_rd_src(i_rd_src),
    .o_rd_addr(i_rd_addr));
  always #12.5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string n, input fbep_word_t e, input fbep_word_t g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input fbep_src_t s, input fbep_waddr_t a, input fbep_word_t d, input logic f);
    fbep_req_model_inst.issue(s, a);
    chk("rd_valid", 32'h1, {31'h0, o_rd_valid});
    chk("rd_fault", {31'h0, f}, {31'h0, o_rd_fault});
    chk("rd_data", d, o_rd_data);
  endtask
  task automatic cmd(input fbep_cmd_t c, input fbep_waddr_t a, input fbep_word_t d, input logic f);
    int n;
    int e;
    // an accepted erase walks the unit a word per clock; all else answers at once
    e = (c == FBEP_CMD_ERASE && !f) ? `FBEP_UNIT_WORDS : 0;
    @(posedge i_clk_sys) #1;
    chk("wr_ready", 32'h1, {31'h0, o_wr_ready});
    i_wr_req = 1'b1;
    i_wr_cmd = c;
    i_wr_addr = a;
    i_wr_data = d;
    @(posedge i_clk_sys) #1;
    i_wr_req = 1'b0;
    chk("wr_busy", {31'h0, e == 0}, {31'h0, o_wr_ready});
    n = 0;
    while (o_wr_done !== 1'b1 && n < 300)
    begin
      @(posedge i_clk_sys) #1;
      n++;
    end
    chk("wr_cycles", e, n);
    chk("wr_done", 32'h1, {31'h0, o_wr_done});
    chk("wr_fault", {31'h0, f}, {31'h0, o_wr_fault});
  endtask
  task automatic t_erase;
    cmd(FBEP_CMD_ERASE, 16'h0000, 32'h0, 1'b0);
    cmd(FBEP_CMD_ERASE, 16'h0100, 32'h0, 1'b0);
    cmd(FBEP_CMD_PROGRAM, 16'h0100, 32'h0000a5a5, 1'b0);
    cmd(FBEP_CMD_ERASE, 16'h0080, 32'h0, 1'b0);
    rd(FBEP_SRC_DATA, 16'h0100, 32'h0000a5a5, 1'b0);
    rd(FBEP_SRC_DEBUG, 16'h00ff, 32'hffffffff, 1'b0);
    cmd(FBEP_CMD_ERASE, 16'hff00, 32'h0, 1'b0);
    rd(FBEP_SRC_IFETCH, 16'hffff, 32'hffffffff, 1'b0);
    $display("test erase done");
  endtask
  task automatic t_ro;
    i_prot_ro[0] = 1'b1;
    cmd(FBEP_CMD_PROGRAM, 16'h0000, 32'h0, 1'b1);
    cmd(FBEP_CMD_ERASE, 16'h0100, 32'h0, 1'b1);
    rd(FBEP_SRC_DATA, 16'h0000, 32'hffffffff, 1'b0);
    rd(FBEP_SRC_DEBUG, 16'h0100, 32'h0000a5a5, 1'b0);
    cmd(FBEP_CMD_ERASE, 16'h0200, 32'h0, 1'b0);
    rd(FBEP_SRC_DEBUG, 16'h02ff, 32'hffffffff, 1'b0);
    cmd(FBEP_CMD_PROGRAM, 16'hff00, 32'h0f0f0f0f, 1'b0);
    rd(FBEP_SRC_DATA, 16'hff00, 32'h0f0f0f0f, 1'b0);
    i_prot_ro[0] = 1'b0;
    $display("test read-only done");
  endtask
  task automatic t_xo;
    i_prot_xo[0] = 1'b1;
    rd(FBEP_SRC_IFETCH, 16'h0100, 32'h0000a5a5, 1'b0);
    rd(FBEP_SRC_DATA, 16'h0100, 32'h0, 1'b1);
    rd(FBEP_SRC_DEBUG, 16'h0000, 32'h0, 1'b1);
    cmd(FBEP_CMD_ERASE, 16'h0100, 32'h0, 1'b1);
    cmd(FBEP_CMD_PROGRAM, 16'h0000, 32'h0, 1'b1);
    i_prot_xo[0] = 1'b0;
    rd(FBEP_SRC_DATA, 16'h0000, 32'hffffffff, 1'b0);
    $display("test execute-only done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // about 1340 cycles are needed; the ceiling leaves ample room
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    #1 i_rst_b = 1'b1;
    t_erase();
    t_ro();
    t_xo();
    report_and_stop();
  end
endmodule
